// file: verilog/video_stream_to_timed_output.sv
`timescale 1ns/100ps
//Contract
//- async high reset, released on stream edge
//- stream and control logic on stream clock
//- video outputs timed by stream clock; video_clk unused
//- stall blocks transactions; host holds request
//- read drives register, write captures data
//- control ports always exist, but act only with option
//- accept high only when word takeable
//- rising frame reference starts aligned frame
//- frame-start output rises at programmed line
//- valid flags high while frame-starts usable
//- interrupt after status change, host reads
//- underflow output mirrors sticky bit, resynchronised
//- output video clock divided by divisor
//- active flag marks active samples, held low in embedded mode
//- field output separates interlaced fields, held low in embedded mode
//- blanking outputs during blanking intervals
//- sync outputs during sync intervals, held low in embedded mode
//- marker at reference sequences with line
//- mode notice pulses cycle before change
module video_stream_to_timed_output
    import vid_out_pkg::*;
#(
    parameter int  DW       = 20,  // pixel width
    parameter int  CW       = 16,  // control data width
    parameter bit  HOST_EN  = 1'b1 // control port build option
) (
    input  wire logic          sys_clk,             // stream side clock
    input  wire logic          sys_rst,
    input  wire logic          ce,
    input  wire logic          video_clk,
    input  wire logic [3:0]    ctl_word_index,
    input  wire logic          ctl_rd_strobe,
    input  wire logic          ctl_wr_strobe,
    input  wire logic [CW-1:0] ctl_wr_bus,
    output logic [CW-1:0]      ctl_rd_bus,
    output logic               ctl_stall,
    output logic               status_irq,
    output logic               underflow_out,
    input  wire logic [DW-1:0] stream_in_word,
    input  wire logic          packet_first_flag,
    input  wire logic          packet_last_flag,
    input  wire logic          stream_in_qualifier,
    output logic               stream_in_accept,
    input  wire logic          frame_ref_in,
    output logic               frame_ref_locked,
    output logic               vco_ref_out,
    output logic [DW-1:0]      pixel_out,
    output logic               active_out,
    output logic               field_out,
    output logic               line_blank,
    output logic               frame_blank,
    output logic               line_sync,
    output logic               frame_sync,
    output logic               trs_marker,
    output logic [10:0]        line_number_out,
    output logic               mode_switch_notice,
    output logic               frame_start_out,
    output logic               frame_start_valid,
    output logic [CW-1:0]      standard_out
);
    // single clock build: the video clock port is kept for the link but the
    // timing runs on sys_clk, so video_clk is deliberately left unused
    logic [CW-1:0] regs [NUM_REGS];   // register file
    logic [CW-1:0] next_regs [NUM_REGS];
    logic          uf_sticky;         // sticky underflow
    logic          next_uf_sticky;
    logic          irq;
    logic          next_irq;
    logic [1:0]    wait_cnt;          // stall counter
    logic [1:0]    next_wait_cnt;
    logic [CW-1:0] next_rd_bus;
    logic          uf_event;          // due pixel missing
    logic          ctl_take;

    // a request is taken once the stall has run out; a frozen block
    // cannot take anything, so it keeps stalling while ce is low
    assign ctl_take = HOST_EN && ce && (ctl_rd_strobe || ctl_wr_strobe)
                      && (wait_cnt == 2'(CTL_WAIT));
    assign ctl_stall = HOST_EN && (ctl_rd_strobe || ctl_wr_strobe)
                       && (wait_cnt != 2'(CTL_WAIT) || !ce);

    // control port next state
    always_comb begin
        next_regs      = regs;
        next_uf_sticky = uf_sticky;
        next_irq       = irq;
        next_rd_bus    = ctl_rd_bus;
        next_wait_cnt  = wait_cnt;
        if (ctl_rd_strobe || ctl_wr_strobe) begin
            next_wait_cnt = ctl_take ? 2'd0 : wait_cnt + 2'd1;
        end else begin
            next_wait_cnt = 2'd0;
        end
        if (ctl_take && ctl_rd_strobe) begin
            // index is a word offset, not a byte address
            if (ctl_word_index == REG_STATUS) begin
                next_rd_bus = CW'(uf_sticky);
            end else if (ctl_word_index < 4'(NUM_REGS)) begin
                next_rd_bus = regs[ctl_word_index];
            end else begin
                next_rd_bus = '0;                                    // unmapped
            end
        end
        if (ctl_take && ctl_wr_strobe) begin
            if (ctl_word_index == REG_STATUS) begin
                if (ctl_wr_bus[STAT_UF_BIT]) begin
                    next_uf_sticky = 1'b0;
                    next_irq       = 1'b0;
                end
            end else if (ctl_word_index < 4'(NUM_REGS)) begin
                next_regs[ctl_word_index] = ctl_wr_bus;
            end
        end
        // set wins over a clear in the same cycle
        if (uf_event) begin
            next_uf_sticky = 1'b1;
            if (!uf_sticky && regs[REG_INT_MASK][STAT_UF_BIT]) begin
                next_irq = 1'b1;
            end
        end
    end

    // control port registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= '0;
            end
            regs[REG_H_ACTIVE] <= RST_H_ACTIVE;
            regs[REG_H_FRONT]  <= RST_H_FRONT;
            regs[REG_H_SYNC]   <= RST_H_SYNC;
            regs[REG_H_BACK]   <= RST_H_BACK;
            regs[REG_V_ACTIVE] <= RST_V_ACTIVE;
            regs[REG_V_FRONT]  <= RST_V_FRONT;
            regs[REG_V_SYNC]   <= RST_V_SYNC;
            regs[REG_V_BACK]   <= RST_V_BACK;
            regs[REG_DIVIDER]  <= RST_DIVIDER;
            uf_sticky  <= 1'b0;
            irq        <= 1'b0;
            ctl_rd_bus <= '0;
            wait_cnt   <= 2'd0;
        end else if (ce) begin
            regs       <= next_regs;
            uf_sticky  <= next_uf_sticky;
            irq        <= next_irq;
            ctl_rd_bus <= next_rd_bus;
            wait_cnt   <= next_wait_cnt;
        end
    end

    assign status_irq   = HOST_EN && irq;
    assign standard_out = regs[REG_STANDARD];

    // ---- timing generator ----
    gen_state_t    state;
    gen_state_t    next_state;
    logic [15:0]   hcnt;
    logic [15:0]   next_hcnt;
    logic [15:0]   vcnt;
    logic [15:0]   next_vcnt;
    logic          field;
    logic          next_field;
    logic          ref_d;             // previous reference level
    logic          mode_q;            // last applied embedded bit
    logic [15:0]   h_total;
    logic [15:0]   v_total;
    logic          go;
    logic          ref_rise;
    logic          h_act;
    logic          v_act;
    logic          due;

    assign go       = regs[REG_CONTROL][CTL_GO_BIT];
    assign h_total  = regs[REG_H_ACTIVE] + regs[REG_H_FRONT]
                      + regs[REG_H_SYNC] + regs[REG_H_BACK];
    assign v_total  = regs[REG_V_ACTIVE] + regs[REG_V_FRONT]
                      + regs[REG_V_SYNC] + regs[REG_V_BACK];
    assign ref_rise = frame_ref_in && !ref_d;
    assign h_act    = hcnt < regs[REG_H_ACTIVE];
    assign v_act    = vcnt < regs[REG_V_ACTIVE];
    assign due      = (state == ST_RUN) && h_act && v_act;
    assign uf_event = due && !stream_in_qualifier;
    // pixels are taken only when an active sample is due and the block
    // is not frozen, otherwise the source would lose a word
    assign stream_in_accept = due && ce;

    // counters and lock state
    always_comb begin
        next_state = state;
        next_hcnt  = hcnt;
        next_vcnt  = vcnt;
        next_field = field;
        unique case (state)
            ST_IDLE: begin
                if (go) begin
                    next_state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                // wait for the reference edge, then start at line zero
                if (!go) begin
                    next_state = ST_IDLE;
                end else if (ref_rise) begin
                    next_state = ST_RUN;
                    next_hcnt  = '0;
                    next_vcnt  = '0;
                    next_field = 1'b0;
                end
            end
            ST_RUN: begin
                if (!go) begin
                    next_state = ST_IDLE;
                end else if (ref_rise) begin
                    next_hcnt  = '0;
                    next_vcnt  = '0;
                end else if (hcnt >= h_total - 16'd1) begin
                    next_hcnt = '0;
                    if (vcnt >= v_total - 16'd1) begin
                        next_vcnt  = '0;
                        next_field = regs[REG_INTERLACE][0] && !field;
                    end else begin
                        next_vcnt = vcnt + 16'd1;
                    end
                end else begin
                    next_hcnt = hcnt + 16'd1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // output timing decode, all registered
    logic [15:0] hs_lo;
    logic [15:0] vs_lo;
    assign hs_lo = regs[REG_H_ACTIVE] + regs[REG_H_FRONT];
    assign vs_lo = regs[REG_V_ACTIVE] + regs[REG_V_FRONT];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state              <= ST_IDLE;
            hcnt               <= '0;
            vcnt               <= '0;
            field              <= 1'b0;
            ref_d              <= 1'b0;
            mode_q             <= 1'b0;
            pixel_out          <= '0;
            active_out         <= 1'b0;
            field_out          <= 1'b0;
            line_blank         <= 1'b1;
            frame_blank        <= 1'b1;
            line_sync          <= 1'b0;
            frame_sync         <= 1'b0;
            trs_marker         <= 1'b0;
            line_number_out    <= '0;
            mode_switch_notice <= 1'b0;
            frame_start_out    <= 1'b0;
        end else if (ce) begin
            state  <= next_state;
            hcnt   <= next_hcnt;
            vcnt   <= next_vcnt;
            field  <= next_field;
            ref_d  <= frame_ref_in;
            // notice lands one cycle before the new mode is applied
            mode_switch_notice <= regs[REG_CONTROL][CTL_EMB_BIT] != mode_q
                                  && !mode_switch_notice;
            if (mode_switch_notice) begin
                mode_q <= regs[REG_CONTROL][CTL_EMB_BIT];
            end
            pixel_out  <= due ? stream_in_word : '0;
            active_out <= due && !mode_q;
            field_out  <= field && !mode_q;
            line_blank <= !h_act;
            frame_blank <= !v_act;
            line_sync  <= !mode_q && hcnt >= hs_lo
                          && hcnt < hs_lo + regs[REG_H_SYNC];
            frame_sync <= !mode_q && vcnt >= vs_lo
                          && vcnt < vs_lo + regs[REG_V_SYNC];
            // timing reference at start and end of the active part of every line
            trs_marker <= mode_q && (state == ST_RUN)
                          && (hcnt == '0 || hcnt == regs[REG_H_ACTIVE]);
            line_number_out <= 11'(vcnt + 16'd1);
            frame_start_out <= (state == ST_RUN) && hcnt == '0
                               && vcnt == regs[REG_SOF_LINE];
        end
    end

    // lock flags high only while running in step with the reference
    assign frame_start_valid = (state == ST_RUN);
    assign frame_ref_locked  = (state == ST_RUN);

    // underflow mirror through two stages
    logic uf_s1;
    logic uf_s2;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            uf_s1 <= 1'b0;
            uf_s2 <= 1'b0;
        end else if (ce) begin
            uf_s1 <= uf_sticky;
            uf_s2 <= uf_s1;
        end
    end
    assign underflow_out = HOST_EN && uf_s2;

    clk_divider #(
        .W (16)
    ) u_div (
        .clk     (sys_clk),
        .rst     (sys_rst),
        .ce      (ce),
        .divisor (regs[REG_DIVIDER]),
        .div_out (vco_ref_out)
    );
endmodule

// file: verilog/vid_out_pkg.sv
package vid_out_pkg;
    // control word indices
    localparam logic [3:0]  REG_CONTROL   = 4'h0;  // bit0 go, bit1 embedded
    localparam logic [3:0]  REG_STATUS    = 4'h1;  // bit0 underflow, write 1 clears
    localparam logic [3:0]  REG_H_ACTIVE  = 4'h2;
    localparam logic [3:0]  REG_H_FRONT   = 4'h3;
    localparam logic [3:0]  REG_H_SYNC    = 4'h4;
    localparam logic [3:0]  REG_H_BACK    = 4'h5;
    localparam logic [3:0]  REG_V_ACTIVE  = 4'h6;
    localparam logic [3:0]  REG_V_FRONT   = 4'h7;
    localparam logic [3:0]  REG_V_SYNC    = 4'h8;
    localparam logic [3:0]  REG_V_BACK    = 4'h9;
    localparam logic [3:0]  REG_SOF_LINE  = 4'hA;
    localparam logic [3:0]  REG_DIVIDER   = 4'hB;
    localparam logic [3:0]  REG_INT_MASK  = 4'hC;
    localparam logic [3:0]  REG_STANDARD  = 4'hD;
    localparam logic [3:0]  REG_INTERLACE = 4'hE;
    localparam int          NUM_REGS      = 15;
    // field positions
    localparam int          CTL_GO_BIT    = 0;
    localparam int          CTL_EMB_BIT   = 1;
    localparam int          STAT_UF_BIT   = 0;
    // reset values
    localparam logic [15:0] RST_H_ACTIVE  = 16'h0280;
    localparam logic [15:0] RST_H_FRONT   = 16'h0010;
    localparam logic [15:0] RST_H_SYNC    = 16'h0060;
    localparam logic [15:0] RST_H_BACK    = 16'h0030;
    localparam logic [15:0] RST_V_ACTIVE  = 16'h01E0;
    localparam logic [15:0] RST_V_FRONT   = 16'h000A;
    localparam logic [15:0] RST_V_SYNC    = 16'h0002;
    localparam logic [15:0] RST_V_BACK    = 16'h0021;
    localparam logic [15:0] RST_DIVIDER   = 16'h0320;
    // stall cycles on each control access
    localparam int          CTL_WAIT      = 1;
    // timing generator states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOCK  = 2'b01,
        ST_RUN   = 2'b10
    } gen_state_t;
endpackage

// file: verilog/clk_divider.sv
`timescale 1ns/100ps
// programmable divider of the video clock; a zero divisor holds the output low
module clk_divider #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] divisor,
    output logic              div_out
);
    logic [W-1:0] count;       // cycles into the period
    logic [W-1:0] next_count;
    logic         next_div_out;

    // high for the first divisor>>1 cycles of each period
    always_comb begin
        next_count   = count;
        next_div_out = div_out;
        if (divisor == '0) begin
            next_count   = '0;
            next_div_out = 1'b0;
        end else begin
            if (count >= divisor - W'(1)) begin
                next_count = '0;
            end else begin
                next_count = count + W'(1);
            end
            next_div_out = (next_count < (divisor >> 1));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count   <= '0;
            div_out <= 1'b0;
        end else if (ce) begin
            count   <= next_count;
            div_out <= next_div_out;
        end
    end
endmodule

// file: test/vso_checker.sv
`timescale 1ns/100ps
// port-level checks of the video output block, one clock domain
module vso_checker #(
    parameter int CW = 16
) (
    input wire logic          sys_clk,
    input wire logic          sys_rst,
    input wire logic [3:0]    ctl_word_index,
    input wire logic          ctl_rd_strobe,
    input wire logic          ctl_wr_strobe,
    input wire logic [CW-1:0] ctl_rd_bus,
    input wire logic          ctl_stall,
    input wire logic          status_irq,
    input wire logic          underflow_out,
    input wire logic          stream_in_accept,
    input wire logic          frame_ref_locked,
    input wire logic          frame_start_valid,
    input wire logic          frame_start_out,
    input wire logic          active_out,
    input wire logic          line_blank,
    input wire logic          frame_blank,
    input wire logic          line_sync,
    input wire logic          frame_sync,
    input wire logic          mode_switch_notice
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic req; // any control strobe held
    assign req = ctl_rd_strobe | ctl_wr_strobe;
    // a fresh request, then its take after one stalled cycle
    sequence s_new_req;
        req && !$past(req);
    endsequence
    sequence s_take_unmapped;
        ctl_rd_strobe && !ctl_stall && ctl_word_index == 4'hF;
    endsequence
    property p_stall_first; s_new_req |-> ctl_stall; endproperty
    property p_stall_once; ctl_stall |=> !ctl_stall; endproperty
    property p_unmapped; s_take_unmapped |=> ctl_rd_bus == '0; endproperty
    property p_accept; stream_in_accept |=> !line_blank && !frame_blank;
    endproperty
    property p_valid; frame_start_out |-> frame_start_valid; endproperty
    property p_active; active_out |-> !line_blank && !frame_blank;
    endproperty
    property p_hsync; line_sync |-> line_blank; endproperty
    property p_vsync; frame_sync |-> frame_blank; endproperty
    property p_notice; mode_switch_notice |=> !mode_switch_notice;
    endproperty
    // the sticky mirror only drops within three cycles of a control write
    property p_uf_hold;
        $fell(underflow_out) |-> $past(ctl_wr_strobe, 1)
            || $past(ctl_wr_strobe, 2) || $past(ctl_wr_strobe, 3);
    endproperty
    property p_irq; $rose(status_irq) |-> ##[0:4] underflow_out; endproperty
    a_stall_first: assert property (p_stall_first)
        else $error("stall missing on new request");
    a_stall_once: assert property (p_stall_once)
        else $error("stall longer than one cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_accept: assert property (p_accept)
        else $error("accept outside the active window");
    a_valid: assert property (p_valid)
        else $error("frame start pulse while not valid");
    a_active: assert property (p_active)
        else $error("active sample inside blanking");
    a_hsync: assert property (p_hsync)
        else $error("line sync outside line blanking");
    a_vsync: assert property (p_vsync)
        else $error("frame sync outside frame blanking");
    a_notice: assert property (p_notice)
        else $error("mode notice longer than one cycle");
    a_uf_hold: assert property (p_uf_hold)
        else $error("underflow dropped without clear");
    a_irq: assert property (p_irq)
        else $error("interrupt without underflow");
endmodule

// file: test/stream_source.sv
`timescale 1ns/100ps
// upstream pixel source: always ready while enabled, frames of FW words
module stream_source #(
    parameter int DW = 20,
    parameter int FW = 8
) (
    input  wire logic     sys_clk,
    input  wire logic     sys_rst,
    input  wire logic     enable,
    input  wire logic     stream_in_accept,
    output logic [DW-1:0] stream_in_word,
    output logic          packet_first_flag,
    output logic          packet_last_flag,
    output logic          stream_in_qualifier
);
    int   cnt;   // words handed over
    logic taken; // a word left at the last rising edge
    always @(posedge sys_clk) begin
        taken <= stream_in_accept & stream_in_qualifier & ~sys_rst;
    end
    // drive on the falling edge; an idle bus shows the inverted word
    always @(negedge sys_clk) begin
        if (sys_rst) begin
            cnt = 0;
        end else if (taken) begin
            cnt = cnt + 1;
        end
        stream_in_qualifier <= enable;
        stream_in_word <= enable ? DW'(cnt * 3 + 1) : ~DW'(cnt * 3 + 1);
        packet_first_flag <= enable && cnt % FW == 0;
        packet_last_flag <= enable && cnt % FW == FW - 1;
    end
endmodule

// file: test/test_video_stream_to_timed_output.sv
`timescale 1ns/100ps
module test_video_stream_to_timed_output
    import vid_out_pkg::*;
;
    localparam int DW = 20;
    localparam int CW = 16;
    logic sys_clk, sys_rst, ce, video_clk, ctl_rd_strobe, ctl_wr_strobe;
    logic [3:0] ctl_word_index;
    logic [CW-1:0] ctl_wr_bus, ctl_rd_bus, standard_out, rd, r;
    logic ctl_stall, status_irq, underflow_out, stream_in_accept;
    logic [DW-1:0] stream_in_word, pixel_out;
    logic packet_first_flag, packet_last_flag, stream_in_qualifier;
    logic frame_ref_in, frame_ref_locked, vco_ref_out, active_out;
    logic field_out, line_blank, frame_blank, line_sync, frame_sync;
    logic trs_marker, mode_switch_notice, frame_start_out;
    logic frame_start_valid, src_en, cmp_pix, vco_q;
    logic [10:0] line_number_out;
    logic [15:0] regm [16];   // expected register contents
    logic [DW-1:0] pq [$];    // words taken, not yet shown
    int error_cnt, samples_checked, cyc, vco_last, vco_per, npix;
    // one clock serves both sides in this build
    assign video_clk = sys_clk;
    video_stream_to_timed_output #(.DW(DW), .CW(CW)) uut (.sys_clk, .sys_rst,
        .ce, .video_clk, .ctl_word_index, .ctl_rd_strobe, .ctl_wr_strobe,
        .ctl_wr_bus, .ctl_rd_bus, .ctl_stall, .status_irq, .underflow_out,
        .stream_in_word, .packet_first_flag, .packet_last_flag,
        .stream_in_qualifier, .stream_in_accept, .frame_ref_in,
        .frame_ref_locked, .vco_ref_out, .pixel_out, .active_out, .field_out,
        .line_blank, .frame_blank, .line_sync, .frame_sync, .trs_marker,
        .line_number_out, .mode_switch_notice, .frame_start_out,
        .frame_start_valid, .standard_out);
    stream_source #(.DW(DW), .FW(8)) src (.sys_clk, .sys_rst,
        .enable(src_en), .stream_in_accept, .stream_in_word,
        .packet_first_flag, .packet_last_flag, .stream_in_qualifier);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_px(input logic [DW-1:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] pixel expected %h seen %h", e, g);
        end
    endtask
    // one control access: hold strobe through the stalled cycle
    task automatic ctl(input logic wr, input logic [3:0] idx,
                       input logic [15:0] wd, output logic [15:0] q);
        int n;
        n = 0;
        @(negedge sys_clk);
        {ctl_word_index, ctl_wr_bus} = {idx, wd};
        {ctl_wr_strobe, ctl_rd_strobe} = {wr, !wr};
        do begin
            @(negedge sys_clk);
            n++;
        end while (ctl_stall !== 1'b0 && n < 8);
        if (n >= 8) begin
            chk("stall", 16'h0000, 16'h0001);
            complete_run();
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        {ctl_wr_strobe, ctl_rd_strobe} = 2'b00;
        if (wr && idx != REG_STATUS && idx != 4'hF) regm[idx] = wd;
        @(negedge sys_clk);
        q = ctl_rd_bus;
    endtask
    task automatic rd_chk(input logic [3:0] idx);
        ctl(1'b0, idx, 16'h0000, rd);
        chk("register", regm[idx], rd);
    endtask
    task automatic wait_for(input int sel, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge sys_clk);
            case (sel)
                0: hit = frame_ref_locked === 1'b1;
                1: hit = frame_start_out === 1'b1;
                2: hit = mode_switch_notice === 1'b1;
                3: hit = trs_marker === 1'b1;
                4: hit = field_out === 1'b1;
                5: hit = line_sync === 1'b1;
                default: hit = frame_sync === 1'b1;
            endcase
        end
        chk("wait", 16'h0001, {15'h0000, hit});
        if (!hit) complete_run();
    endtask
    // queue model of the pixel path, and divided clock period
    always @(posedge sys_clk) begin
        cyc++;
        if (stream_in_accept === 1'b1 && stream_in_qualifier) begin
            pq.push_back(stream_in_word);
        end
        if (cmp_pix && active_out === 1'b1 && pq.size() > 0) begin
            chk_px(pq.pop_front(), pixel_out);
            npix++;
        end
        if (vco_ref_out === 1'b1 && !vco_q) begin
            vco_per = cyc - vco_last;
            vco_last = cyc;
        end
        vco_q = vco_ref_out === 1'b1;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        chk("watchdog", 16'h0000, 16'h0001);
        complete_run();
    end
    initial begin
        {sys_rst, ce, ctl_rd_strobe, ctl_wr_strobe} = 4'b1100;
        {ctl_word_index, ctl_wr_bus, frame_ref_in} = '0;
        {src_en, cmp_pix, vco_q} = 3'b000;
        {error_cnt, samples_checked, cyc, vco_last, vco_per, npix} = '0;
        r = 16'($urandom(32'h6228_a343));
        foreach (regm[i]) regm[i] = 16'h0000;
        {regm[2], regm[3], regm[4], regm[5]} =
            {RST_H_ACTIVE, RST_H_FRONT, RST_H_SYNC, RST_H_BACK};
        {regm[6], regm[7], regm[8], regm[9], regm[11]} = {RST_V_ACTIVE,
            RST_V_FRONT, RST_V_SYNC, RST_V_BACK, RST_DIVIDER};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) rd_chk(4'(i));
        // tiny raster: 4x2 active, one cycle porches and syncs
        for (int i = 2; i < 10; i++) begin
            ctl(1'b1, 4'(i), (i == 2) ? 16'h0004 : (i == 6) ? 16'h0002
                : 16'h0001, rd);
        end
        ctl(1'b1, REG_STANDARD, 16'($urandom()), rd);
        ctl(1'b1, REG_SOF_LINE, 16'($urandom_range(2)), rd);
        ctl(1'b1, 4'hF, 16'($urandom()), rd);
        ctl(1'b1, REG_DIVIDER, 16'($urandom_range(7, 3)), rd);
        ctl(1'b1, REG_INT_MASK, 16'h0001, rd);
        for (int i = 0; i < 16; i++) rd_chk(4'(i));
        chk("standard", regm[13], standard_out);
        repeat (40) @(posedge sys_clk);
        chk("divider", regm[11], 16'(vco_per));
        src_en = 1'b1;
        ctl(1'b1, REG_CONTROL, 16'h0001, rd);
        @(negedge sys_clk);
        frame_ref_in = 1'b1;
        wait_for(0, 8);
        chk("sof valid", 16'h0001, {15'h0000, frame_start_valid});
        cmp_pix = 1'b1;
        wait_for(1, 100);
        repeat (200) @(posedge sys_clk);
        chk("pixels", 16'h0001, {15'h0000, npix >= 32});
        rd_chk(REG_STATUS);
        // starve the output so a due sample finds no word
        @(negedge sys_clk);
        {cmp_pix, src_en} = 2'b00;
        repeat (40) @(posedge sys_clk);
        regm[1] = 16'h0001;
        rd_chk(REG_STATUS);
        chk("underflow", 16'h0001, {15'h0000, underflow_out});
        chk("irq", 16'h0001, {15'h0000, status_irq});
        src_en = 1'b1;
        repeat (40) @(posedge sys_clk);
        rd_chk(REG_STATUS);
        ctl(1'b1, REG_STATUS, 16'h0001, rd);
        repeat (8) @(posedge sys_clk);
        regm[1] = 16'h0000;
        rd_chk(REG_STATUS);
        chk("underflow", 16'h0000, {15'h0000, underflow_out});
        chk("irq", 16'h0000, {15'h0000, status_irq});
        wait_for(5, 20);
        wait_for(6, 60);
        // clock enable low must freeze line number, both blanking outputs and the divided clock
        @(negedge sys_clk);
        ce = 1'b0;
        r = {2'b00, line_number_out, line_blank, frame_blank, vco_ref_out};
        repeat (5) @(posedge sys_clk);
        chk("freeze", r, {2'b00, line_number_out, line_blank, frame_blank,
            vco_ref_out});
        @(negedge sys_clk);
        ce = 1'b1;
        ctl(1'b1, REG_CONTROL, 16'h0003, rd);
        wait_for(2, 10);
        wait_for(3, 40);
        chk("line", 16'h0001,
            {15'h0000, line_number_out inside {[1:5]}});
        ctl(1'b1, REG_CONTROL, 16'h0001, rd);
        ctl(1'b1, REG_INTERLACE, 16'h0001, rd);
        wait_for(4, 100);
        complete_run();
    end
endmodule
bind video_stream_to_timed_output vso_checker #(.CW(CW)) u_chk (.sys_clk,
    .sys_rst, .ctl_word_index, .ctl_rd_strobe, .ctl_wr_strobe, .ctl_rd_bus,
    .ctl_stall, .status_irq, .underflow_out, .stream_in_accept,
    .frame_ref_locked, .frame_start_valid, .frame_start_out,
    .active_out, .line_blank,
    .frame_blank, .line_sync, .frame_sync, .mode_switch_notice);
